/* File: verilog/uart_lms_pkg.sv */
// Constants for the serial line, modem control and line status block
package uart_lms_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_DATA = 12'h140;
  localparam logic [11:0] OFS_FIFO_CTL = 12'h148;
  localparam logic [11:0] OFS_LINE_CTL = 12'h14C;
  localparam logic [11:0] OFS_MODEM_CTL = 12'h150;
  localparam logic [11:0] OFS_LINE_STAT = 12'h154;
  localparam logic [11:0] OFS_MODEM_STAT = 12'h158;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Line control fields
  localparam int LC_STB = 2;
  localparam int LC_PEN = 3;
  localparam int LC_EPS = 4;
  localparam int LC_SP = 5;
  localparam int LC_SB = 6;
  localparam logic [7:0] LINE_CTL_RST = 8'h03;
  // Modem control fields
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_AUXB = 2;
  localparam int MC_AUXA = 3;
  localparam int MC_LOOP = 4;
  localparam logic [7:0] MODEM_CTL_RST = 8'h00;
  localparam logic [7:0] MODEM_CTL_MASK = 8'h1F;
  // Line status fields
  localparam int LS_DR = 0;
  localparam int LS_OE = 1;
  localparam int LS_PE = 2;
  localparam int LS_FE = 3;
  localparam int LS_BI = 4;
  localparam int LS_TX_HOLD_EMPTY = 5;
  localparam int LS_TX_EMPTY = 6;
  localparam int LS_FERR = 7;
  localparam int FC_FIFOE = 0;
  // Receive entry layout: data, parity, framing, break
  localparam int RX_W = 11;
  localparam int RX_PE = 8;
  localparam int RX_FE = 9;
  localparam int RX_BI = 10;
  localparam int PTR_W = 4;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] HOLD_DEPTH = 5'h01;
  // Bit timing
  localparam longint CLK_HZ = 200000000;
  localparam longint BAUD_HZ = 115200;
  localparam longint OVS = 16;
  localparam logic [15:0] OVS_CLKS = 16'(CLK_HZ / (BAUD_HZ * OVS));
  localparam logic [3:0] SAMPLE_TICK = 4'h7;
  localparam logic [3:0] LAST_TICK = 4'hF;
endpackage : uart_lms_pkg

/* File: verilog/uart_fifo_mem.sv */
// Small dual-port memory with registered read data and write-through
`timescale 1ns/100ps
module uart_fifo_mem #(
  parameter int WIDTH = 11,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Head word follows a write to the same slot at once
  always_ff @(posedge clk)
  begin
    if (wr_en && wr_addr == rd_addr)
    begin
      rd_data <= wr_data;
    end
    else
    begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : uart_fifo_mem

/* File: verilog/uart_line_modem_status.sv */
// Serial port core: line format, modem control, loopback and line status
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
// Notes on behaviour
// R1 - Receiver checks only one stop bit
// R2 - Length field selects five to eight data bits
// R3 - Modem control holds five low bits
// R4 - Loopback holds serial output at marking
// R5 - Loopback feeds receiver from transmit shifter
// R6 - Loopback routes modem controls to status inputs
// R7 - Request and ready pins still driven in loopback
// R8 - Line status bit order fixed
// R9 - FIFO error set while erroneous character queued
// R10 - Status read clears FIFO error only when clean
// R11 - Transmitter empty without FIFOs: holding and shifter
// R12 - Transmitter empty with FIFOs: queue and shifter
// R13 - Writing a byte clears transmitter empty
// R14 - Holding empty flag without FIFOs
// R15 - Holding empty flag with FIFOs follows queue
// R16 - Break when line low a whole character
// R17 - Status read clears break without FIFOs
// R18 - Break travels with its character in FIFO
// R19 - Break loads one zero character, waits marking
// R20 - Two stop bits except five-bit characters
// R21 - Status read clears errors; FIFO reports at head
// R22 - Bit zero holds data ready and terminal ready
module uart_line_modem_status
  import uart_lms_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd_in,
  output logic txd_out,
  input wire logic cts_in,
  input wire logic dsr_in,
  input wire logic dcd_in,
  input wire logic ri_in,
  output logic rts_out,
  output logic dtr_out
);
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_type;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK}
    rx_state_type;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = a == OFS_DATA || a == OFS_FIFO_CTL || a == OFS_LINE_CTL ||
             a == OFS_MODEM_CTL || a == OFS_LINE_STAT || a == OFS_MODEM_STAT;
  endfunction : mapped

  // Parity bit for the selected length and mode
  function automatic logic par_bit(input logic [7:0] d, input logic [7:0] lc);
    logic [7:0] m;
    m = d & (8'hFF >> (3 - lc[1:0]));
    if (lc[LC_SP])
      par_bit = !lc[LC_EPS];
    else
      par_bit = lc[LC_EPS] ? ^m : ~^m;
  endfunction : par_bit

  logic [7:0] line_ctl_r, modem_ctl_r;
  logic fifo_en_r, flush;
  logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r, rdata_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  logic wr_fire, rd_fire, lsr_read, rx_pop, tx_push, tx_pop, rx_push;
  logic loop, tx_line_r, rx_src, ovs_tick, tx_busy;
  logic [15:0] ovs_cnt_r;
  logic [7:0] lsr_bits;
  logic [3:0] msr_bits;
  logic [2:0] len_m1;
  logic [4:0] tx_cnt_r, rx_cnt_r, rx_err_cnt_r;
  logic [PTR_W-1:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
  logic [7:0] tx_rdata;
  logic [RX_W-1:0] rx_rdata, rx_entry;
  logic rx_full, rx_overwrite, oe_r, pe_r, fe_r, bi_r, fifo_err_r;
  tx_state_type tx_state_r;
  rx_state_type rx_state_r;
  logic [3:0] tx_tick_r, rx_tick_r;
  logic [2:0] tx_idx_r, rx_idx_r;
  logic [7:0] tx_sh_r, rx_sh_r;
  logic tx_two_r, rx_par_r;

  assign loop = modem_ctl_r[MC_LOOP];
  assign len_m1 = {1'b1, line_ctl_r[1:0]}; // see R2
  assign rts_out = modem_ctl_r[MC_RTS]; // see R7
  assign dtr_out = modem_ctl_r[MC_DTR]; // see R7
  assign txd_out = loop ? 1'b1 : (!line_ctl_r[LC_SB] && tx_line_r); // see R4
  assign rx_src = loop ? tx_line_r : rxd_in; // see R5
  // Order: carrier, ring, set ready, clear to send
  assign msr_bits = loop ? {modem_ctl_r[MC_AUXA], modem_ctl_r[MC_AUXB], // see R6
                            modem_ctl_r[MC_DTR], modem_ctl_r[MC_RTS]}
                         : {dcd_in, ri_in, dsr_in, cts_in};

  // Register bus: write path
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign wr_fire = aw_held_r && w_held_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_r && s_axi_bready)
      begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Control registers written from byte lane 0
  assign flush = wr_fire && w_strb_r[0] && aw_addr_r == OFS_FIFO_CTL &&
                 w_data_r[FC_FIFOE] != fifo_en_r;
  assign tx_push = wr_fire && w_strb_r[0] && aw_addr_r == OFS_DATA &&
                   tx_cnt_r != (fifo_en_r ? FIFO_DEPTH : HOLD_DEPTH);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      line_ctl_r <= LINE_CTL_RST;
      modem_ctl_r <= MODEM_CTL_RST;
      fifo_en_r <= 1'b0;
    end
    else if (wr_fire && w_strb_r[0])
    begin
      if (aw_addr_r == OFS_LINE_CTL)
        line_ctl_r <= w_data_r[7:0];
      if (aw_addr_r == OFS_MODEM_CTL)
        modem_ctl_r <= w_data_r[7:0] & MODEM_CTL_MASK; // see R3
      if (aw_addr_r == OFS_FIFO_CTL)
        fifo_en_r <= w_data_r[FC_FIFOE];
    end
  end

  // Register bus: read path
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign lsr_read = rd_fire && s_axi_araddr == OFS_LINE_STAT;
  assign rx_pop = rd_fire && s_axi_araddr == OFS_DATA && rx_cnt_r != 5'h00;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_r <= 1'b1;
      rresp_r <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFS_DATA: rdata_r <= {24'h000000, rx_rdata[7:0]};
        OFS_FIFO_CTL: rdata_r <= {31'h00000000, fifo_en_r};
        OFS_LINE_CTL: rdata_r <= {24'h000000, line_ctl_r};
        OFS_MODEM_CTL: rdata_r <= {24'h000000, modem_ctl_r};
        OFS_LINE_STAT: rdata_r <= {24'h000000, lsr_bits};
        OFS_MODEM_STAT: rdata_r <= {24'h000000, msr_bits, 4'h0};
        default: rdata_r <= '0;
      endcase
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_r <= 1'b0;
    end
  end

  // Line status, most significant first
  assign lsr_bits = {fifo_err_r, // see R8
                     tx_cnt_r == 5'h00 && !tx_busy, // see R11 R12 R13
                     tx_cnt_r == 5'h00, // see R14 R15
                     fifo_en_r ? rx_cnt_r != 5'h00 && rx_rdata[RX_BI] : bi_r,
                     fifo_en_r ? rx_cnt_r != 5'h00 && rx_rdata[RX_FE] : fe_r,
                     fifo_en_r ? rx_cnt_r != 5'h00 && rx_rdata[RX_PE] : pe_r,
                     oe_r, rx_cnt_r != 5'h00}; // see R18 R21 R22

  // Oversample tick, sixteen per bit
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ovs_cnt_r <= '0;
    else
      ovs_cnt_r <= ovs_tick ? 16'h0000 : ovs_cnt_r + 16'h0001;
  end
  assign ovs_tick = ovs_cnt_r == OVS_CLKS - 16'h0001;

  // Transmit queue (depth one without FIFOs)
  assign tx_busy = tx_state_r != TX_IDLE;
  assign tx_pop = !tx_busy && tx_cnt_r != 5'h00 && ovs_tick;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_cnt_r <= '0;
      tx_wp_r <= '0;
      tx_rp_r <= '0;
    end
    else if (flush)
    begin
      tx_cnt_r <= '0;
      tx_wp_r <= '0;
      tx_rp_r <= '0;
    end
    else
    begin
      if (tx_push)
        tx_wp_r <= tx_wp_r + 4'h1;
      if (tx_pop)
        tx_rp_r <= tx_rp_r + 4'h1;
      tx_cnt_r <= tx_cnt_r + {4'h0, tx_push} - {4'h0, tx_pop};
    end
  end

  uart_fifo_mem #(.WIDTH(8), .AW(PTR_W)) u_tx_mem (
    .clk(clk),
    .wr_en(tx_push),
    .wr_addr(tx_wp_r),
    .wr_data(w_data_r[7:0]),
    .rd_addr(tx_rp_r),
    .rd_data(tx_rdata)
  );

  // Transmit shifter
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_state_r <= TX_IDLE;
      tx_line_r <= 1'b1;
      tx_tick_r <= '0;
      tx_idx_r <= '0;
      tx_sh_r <= '0;
      tx_two_r <= 1'b0;
    end
    else if (tx_pop)
    begin
      tx_state_r <= TX_START;
      tx_line_r <= 1'b0;
      tx_tick_r <= '0;
      tx_idx_r <= '0;
      tx_sh_r <= tx_rdata;
      tx_two_r <= line_ctl_r[LC_STB] && line_ctl_r[1:0] != 2'b00; // see R20
    end
    else if (ovs_tick && tx_busy)
    begin
      tx_tick_r <= tx_tick_r + 4'h1;
      if (tx_tick_r == LAST_TICK)
      begin
        case (tx_state_r)
          TX_START, TX_DATA:
          begin
            if (tx_state_r == TX_DATA && tx_idx_r == len_m1)
            begin
              tx_state_r <= line_ctl_r[LC_PEN] ? TX_PAR : TX_STOP;
              tx_line_r <= line_ctl_r[LC_PEN] ? par_bit(tx_sh_r, line_ctl_r)
                                              : 1'b1;
            end
            else
            begin
              tx_state_r <= TX_DATA;
              tx_line_r <= tx_sh_r[tx_idx_r + {2'b00, tx_state_r == TX_DATA}];
              tx_idx_r <= tx_idx_r + {2'b00, tx_state_r == TX_DATA};
            end
          end
          TX_PAR:
          begin
            tx_state_r <= TX_STOP;
            tx_line_r <= 1'b1;
          end
          TX_STOP:
          begin
            tx_two_r <= 1'b0; // see R20
            if (!tx_two_r)
              tx_state_r <= TX_IDLE;
          end
          default: tx_state_r <= TX_IDLE;
        endcase
      end
    end
  end

  // Receive shifter
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_state_r <= RX_IDLE;
      rx_tick_r <= '0;
      rx_idx_r <= '0;
      rx_sh_r <= '0;
      rx_par_r <= 1'b0;
    end
    else if (ovs_tick)
    begin
      rx_tick_r <= rx_tick_r + 4'h1;
      case (rx_state_r)
        RX_IDLE:
        begin
          rx_tick_r <= '0;
          rx_idx_r <= '0;
          rx_par_r <= 1'b0;
          rx_sh_r <= '0;
          if (!rx_src)
            rx_state_r <= RX_START;
        end
        RX_START:
        begin
          if (rx_tick_r == SAMPLE_TICK && rx_src)
            rx_state_r <= RX_IDLE;
          else if (rx_tick_r == LAST_TICK)
            rx_state_r <= RX_DATA;
        end
        RX_DATA:
        begin
          if (rx_tick_r == SAMPLE_TICK)
            rx_sh_r[rx_idx_r] <= rx_src;
          if (rx_tick_r == LAST_TICK)
          begin
            rx_idx_r <= rx_idx_r + 3'h1;
            if (rx_idx_r == len_m1) // see R2
              rx_state_r <= line_ctl_r[LC_PEN] ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR:
        begin
          if (rx_tick_r == SAMPLE_TICK)
            rx_par_r <= rx_src;
          if (rx_tick_r == LAST_TICK)
            rx_state_r <= RX_STOP;
        end
        RX_STOP:
        begin
          // One stop bit sampled, then ready for next start
          if (rx_tick_r == SAMPLE_TICK) // see R1
            rx_state_r <= rx_entry[RX_BI] ? RX_BRK : RX_IDLE; // see R19
        end
        RX_BRK:
        begin
          if (rx_src) // see R19
            rx_state_r <= RX_IDLE;
        end
        default: rx_state_r <= RX_IDLE;
      endcase
    end
  end

  // Character with its error bits; break is all zero through stop
  assign rx_entry[7:0] = rx_sh_r;
  assign rx_entry[RX_FE] = !rx_src;
  assign rx_entry[RX_PE] = line_ctl_r[LC_PEN] &&
                           rx_par_r != par_bit(rx_sh_r, line_ctl_r);
  assign rx_entry[RX_BI] = !rx_src && rx_sh_r == 8'h00 && !rx_par_r; // see R16
  assign rx_push = ovs_tick && rx_state_r == RX_STOP &&
                   rx_tick_r == SAMPLE_TICK;
  assign rx_full = rx_cnt_r == (fifo_en_r ? FIFO_DEPTH : HOLD_DEPTH);
  assign rx_overwrite = rx_push && rx_full && !fifo_en_r && !rx_pop;

  // Receive queue (depth one without FIFOs)
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_cnt_r <= '0;
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      rx_err_cnt_r <= '0;
    end
    else if (flush)
    begin
      rx_cnt_r <= '0;
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      rx_err_cnt_r <= '0;
    end
    else
    begin
      if (rx_push && (!rx_full || rx_pop))
        rx_wp_r <= rx_wp_r + 4'h1;
      if (rx_pop)
        rx_rp_r <= rx_rp_r + 4'h1;
      rx_cnt_r <= rx_cnt_r + {4'h0, rx_push && (!rx_full || rx_pop)}
                  - {4'h0, rx_pop};
      if (fifo_en_r) // see R9
        rx_err_cnt_r <= rx_err_cnt_r
          + {4'h0, rx_push && (!rx_full || rx_pop) &&
                   |rx_entry[RX_BI:RX_PE]}
          - {4'h0, rx_pop && |rx_rdata[RX_BI:RX_PE]};
    end
  end

  uart_fifo_mem #(.WIDTH(RX_W), .AW(PTR_W)) u_rx_mem (
    .clk(clk),
    .wr_en(rx_push && (!rx_full || rx_pop || rx_overwrite)),
    .wr_addr(rx_overwrite ? rx_rp_r : rx_wp_r),
    .wr_data(rx_entry),
    .rd_addr(rx_pop ? rx_rp_r + 4'h1 : rx_rp_r),
    .rd_data(rx_rdata)
  );

  // Sticky status flags; a new event wins over the read clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      oe_r <= 1'b0;
      pe_r <= 1'b0;
      fe_r <= 1'b0;
      bi_r <= 1'b0;
      fifo_err_r <= 1'b0;
    end
    else
    begin
      oe_r <= (rx_push && rx_full && !rx_pop) || (oe_r && !lsr_read);
      pe_r <= (rx_push && !fifo_en_r && rx_entry[RX_PE]) ||
              (pe_r && !lsr_read); // see R21
      fe_r <= (rx_push && !fifo_en_r && rx_entry[RX_FE]) ||
              (fe_r && !lsr_read); // see R21
      bi_r <= (rx_push && !fifo_en_r && rx_entry[RX_BI]) ||
              (bi_r && !lsr_read); // see R16 R17
      fifo_err_r <= fifo_en_r && (rx_err_cnt_r != 5'h00 ||
                    (fifo_err_r && !lsr_read)); // see R9 R10
    end
  end

  property p_loop_mark;
    @(posedge clk) disable iff (!reset_n)
    loop |-> txd_out;
  endproperty
  a_loop_mark: assert property (p_loop_mark) // see R4
    else $error("loopback did not hold line at marking");

  property p_loop_status;
    @(posedge clk) disable iff (!reset_n)
    loop |-> msr_bits[0] == rts_out && msr_bits[1] == dtr_out;
  endproperty
  a_loop_status: assert property (p_loop_status) // see R6
    else $error("loopback status not taken from controls");

  property p_pins_in_loop;
    @(posedge clk) disable iff (!reset_n)
    wr_fire && aw_addr_r == OFS_MODEM_CTL && w_strb_r[0] && w_data_r[4]
      |=> loop && rts_out == w_data_r[1] && dtr_out == w_data_r[0];
  endproperty
  a_pins_in_loop: assert property (p_pins_in_loop) // see R7
    else $error("control pins not driven in loopback");

  property p_tx_empty_clear;
    @(posedge clk) disable iff (!reset_n)
    tx_push |=> !lsr_bits[LS_TX_EMPTY] ##1 !lsr_bits[LS_TX_EMPTY];
  endproperty
  a_tx_empty_clear: assert property (p_tx_empty_clear) // see R13
    else $error("transmitter empty stayed set after write");

  property p_tx_hold_empty_fifo;
    @(posedge clk) disable iff (!reset_n)
    fifo_en_r && tx_push |=> !lsr_bits[LS_TX_HOLD_EMPTY];
  endproperty
  a_tx_hold_empty_fifo: assert property (p_tx_hold_empty_fifo) // see R15
    else $error("holding empty stayed set with queued byte");

  property p_ferr_hold;
    @(posedge clk) disable iff (!reset_n)
    fifo_en_r && !flush && lsr_read && !rx_pop && rx_err_cnt_r != 5'h00
      |=> fifo_err_r;
  endproperty
  a_ferr_hold: assert property (p_ferr_hold) // see R10
    else $error("FIFO error cleared while errors remain");

  property p_bi_clear;
    @(posedge clk) disable iff (!reset_n)
    !fifo_en_r && lsr_read && !rx_push |=> !lsr_bits[LS_BI];
  endproperty
  a_bi_clear: assert property (p_bi_clear) // see R17
    else $error("break not cleared by status read");

  property p_rx_len;
    @(posedge clk) disable iff (!reset_n)
    ovs_tick && rx_state_r == RX_DATA && rx_tick_r == LAST_TICK &&
      rx_idx_r == len_m1 |=> rx_state_r != RX_DATA;
  endproperty
  a_rx_len: assert property (p_rx_len) // see R2
    else $error("receiver took wrong number of data bits");
endmodule : uart_line_modem_status

/* File: tb/serial_far_end.sv */
// Far-end serial terminal model for the line status bench
`timescale 1ns/100ps
module serial_far_end #(
  parameter int BIT_CLKS = 1728
) (
  input wire logic clk,
  input wire logic txd_line,
  output logic rxd_line,
  output logic cts_line,
  output logic dsr_line,
  output logic dcd_line,
  output logic ri_line
);
  initial
  begin
    rxd_line = 1'h1;
    {dcd_line, ri_line, dsr_line, cts_line} = 4'h9;
  end
  // Line low for some bit times, then marking
  task automatic send_break(input int nbits);
    rxd_line <= 1'h0;
    repeat (nbits * BIT_CLKS) @(posedge clk);
    rxd_line <= 1'h1;
  endtask : send_break
  // Catch one character, LSB first, ends mid stop bit
  task automatic catch_char(input int nbits, output logic [7:0] d,
    output logic ok);
    int i;
    d = 8'h00;
    ok = 1'h0;
    for (i = 0; i < 40000 && txd_line; i++)
      @(posedge clk);
    if (!txd_line)
    begin
      repeat (BIT_CLKS + BIT_CLKS / 2) @(posedge clk);
      for (i = 0; i < nbits; i++)
      begin
        d[i] = txd_line;
        repeat (BIT_CLKS) @(posedge clk);
      end
      ok = txd_line;
    end
  endtask : catch_char
endmodule : serial_far_end

/* File: tb/uart_line_modem_status_test.sv */
// Self-checking bench for the line, modem control and status block
`timescale 1ns/100ps
module uart_line_modem_status_test;
  import uart_lms_pkg::*;
  localparam int BIT_CLKS = int'(OVS) * int'(OVS_CLKS);
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic rxd, txd, cts, dsr, dcd, ri, rts, dtr;
  int error_cnt = 0;
  int n_tests = 0;
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  uart_line_modem_status u_uart_line_modem_status (.clk(clk),
    .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rxd_in(rxd), .txd_out(txd), .cts_in(cts),
    .dsr_in(dsr), .dcd_in(dcd), .ri_in(ri), .rts_out(rts),
    .dtr_out(dtr));
  serial_far_end #(.BIT_CLKS(BIT_CLKS)) u_serial_far_end (.clk(clk),
    .txd_line(txd), .rxd_line(rxd), .cts_line(cts), .dsr_line(dsr),
    .dcd_line(dcd), .ri_line(ri));
  task automatic tally_and_finish();
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
    output logic [1:0] r);
    int i;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (i = 0; i < 100; i++)
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'h0;
    if (i == 100)
    begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int i;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (i = 0; i < 100; i++)
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    if (i == 100)
    begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : rd
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
    input string what);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(what, exp, d);
  endtask : rd_chk
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rd_chk(OFS_MODEM_CTL, 32'h0, "modem_ctl");
    rd_chk(OFS_LINE_STAT, 32'h60, "line_stat");
    rd(12'h15C, d, r);
    check("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
    wr(12'h15C, 8'hFF, r);
    check("unmapped bresp", 32'(RESP_SLVERR), 32'(r));
  endtask : t_reset
  task automatic t_modem();
    logic [1:0] r;
    wr(OFS_MODEM_CTL, 8'hFF, r);
    rd_chk(OFS_MODEM_CTL, 32'h1F, "modem_ctl");
    check("rts dtr txd", 32'h7, {29'h0, rts, dtr, txd});
    rd_chk(OFS_MODEM_STAT, 32'hF0, "modem_stat");
    wr(OFS_MODEM_CTL, 8'h13, r);
    rd_chk(OFS_MODEM_STAT, 32'h30, "modem_stat");
    wr(OFS_MODEM_CTL, 8'h01, r);
    rd_chk(OFS_MODEM_STAT, 32'h90, "modem_stat");
    check("rts dtr", 32'h1, {30'h0, rts, dtr});
  endtask : t_modem
  task automatic t_loop();
    logic [31:0] d;
    logic [1:0] r;
    wr(OFS_MODEM_CTL, 8'h10, r);
    wr(OFS_LINE_CTL, 8'h07, r);
    wr(OFS_DATA, 8'h5A, r);
    rd(OFS_LINE_STAT, d, r);
    check("tx_empty", 32'h0, {31'h0, d[6]});
    repeat (5 * BIT_CLKS) @(posedge clk);
    check("txd loop", 32'h1, {31'h0, txd});
    repeat (7 * BIT_CLKS) @(posedge clk);
    rd_chk(OFS_LINE_STAT, 32'h61, "line_stat");
    rd_chk(OFS_DATA, 32'h5A, "loop data");
    rd_chk(OFS_LINE_STAT, 32'h60, "line_stat");
    wr(OFS_MODEM_CTL, 8'h00, r);
  endtask : t_loop
  task automatic t_break();
    logic [1:0] r;
    wr(OFS_LINE_CTL, 8'h03, r);
    u_serial_far_end.send_break(12);
    repeat (BIT_CLKS) @(posedge clk);
    rd_chk(OFS_LINE_STAT, 32'h79, "line_stat");
    rd_chk(OFS_LINE_STAT, 32'h61, "line_stat");
    rd_chk(OFS_DATA, 32'h0, "break char");
    rd_chk(OFS_LINE_STAT, 32'h60, "line_stat");
  endtask : t_break
  task automatic t_fifo();
    logic [1:0] r;
    wr(OFS_FIFO_CTL, 8'h01, r);
    u_serial_far_end.send_break(12);
    repeat (BIT_CLKS) @(posedge clk);
    rd_chk(OFS_LINE_STAT, 32'hF9, "line_stat");
    rd_chk(OFS_LINE_STAT, 32'hF9, "line_stat");
    rd_chk(OFS_DATA, 32'h0, "break char");
    rd_chk(OFS_LINE_STAT, 32'hE0, "line_stat");
    rd_chk(OFS_LINE_STAT, 32'h60, "line_stat");
  endtask : t_fifo
  task automatic t_tx();
    logic [31:0] d;
    logic [7:0] c;
    logic [1:0] r;
    logic ok;
    int n;
    wr(OFS_LINE_CTL, 8'h04, r);
    wr(OFS_DATA, 8'hF5, r);
    wr(OFS_DATA, 8'h0A, r);
    rd(OFS_LINE_STAT, d, r);
    check("tx flags", 32'h0, {30'h0, d[6:5]});
    u_serial_far_end.catch_char(5, c, ok);
    check("tx char", 32'h115, {23'h0, ok, c});
    for (n = 0; n < 2 * BIT_CLKS && txd; n++)
      @(posedge clk);
    check("stop short", 32'h1, 32'(n < BIT_CLKS));
    u_serial_far_end.catch_char(5, c, ok);
    check("tx char", 32'h10A, {23'h0, ok, c});
    repeat (BIT_CLKS) @(posedge clk);
    rd_chk(OFS_LINE_STAT, 32'h60, "line_stat");
  endtask : t_tx
  initial
  begin
    repeat (12) @(posedge clk);
    reset_n <= 1'h1;
    t_reset();
    t_modem();
    t_loop();
    t_break();
    t_fifo();
    t_tx();
    tally_and_finish();
  end
endmodule : uart_line_modem_status_test
